// ---- sdi_regs.vh ----
// Constants for the synchronous DRAM command front end: mode register layout,
// field encodings and command codes.
// Assumes inclusion by bare name from the design files.
`ifndef SDI_REGS_VH
`define SDI_REGS_VH
// ----------------------------------------
// Mode register fields
// ----------------------------------------
`define SDI_BL_LSB 0
`define SDI_BL_MSB 2
`define SDI_BT_BIT 3
`define SDI_CL_LSB 4
`define SDI_CL_MSB 6
`define SDI_OPM_LSB 7
`define SDI_OPM_MSB 8
`define SDI_WB_BIT 9
`define SDI_MODE_RESET 13'h0000
// ----------------------------------------
// Field encodings
// ----------------------------------------
`define SDI_BL_1 3'h0
`define SDI_BL_2 3'h1
`define SDI_BL_4 3'h2
`define SDI_BL_8 3'h3
`define SDI_BL_PAGE 3'h7
`define SDI_CL_2 3'h2
`define SDI_CL_3 3'h3
`define SDI_OPM_NORMAL 2'h0
// ----------------------------------------
// Commands {cs_n, ras_n, cas_n, we_n}
// ----------------------------------------
`define SDI_CMD_NOP 4'h7
`define SDI_CMD_ACT 4'h3
`define SDI_CMD_RD 4'h5
`define SDI_CMD_WR 4'h4
`define SDI_CMD_BST 4'h6
`define SDI_CMD_PRE 4'h2
`define SDI_CMD_REF 4'h1
`define SDI_CMD_LMR 4'h0
// ----------------------------------------
// Geometry and timing
// ----------------------------------------
`define SDI_PAGE_COLS 11'h0400
`define SDI_AP_BIT 10
`define SDI_TRP_CYC 3'h2
`endif

// ---- sdi_burst_addr.v ----
// Burst column generator: next column within the aligned burst block.
// Assumes start column and step index supplied by the sequencer.
module sdi_burst_addr #(
    parameter COL_W = 10
) (
    input wire [COL_W-1:0] start_col,
    input wire [COL_W-1:0] step,
    input wire [2:0] burst_len,
    input wire interleaved,
    output reg [COL_W-1:0] col
);
`include "sdi_regs.vh"
    reg [COL_W-1:0] mask;
    always @* begin
        case (burst_len)
            `SDI_BL_2: mask = {{(COL_W-1){1'b0}}, 1'b1};
            `SDI_BL_4: mask = {{(COL_W-2){1'b0}}, 2'b11};
            `SDI_BL_8: mask = {{(COL_W-3){1'b0}}, 3'b111};
            `SDI_BL_PAGE: mask = {COL_W{1'b1}};
            default: mask = {COL_W{1'b0}};
        endcase
        // Wrap inside aligned block; page wraps inside row
        if (interleaved && burst_len != `SDI_BL_PAGE) begin
            col = (start_col & ~mask) | ((start_col ^ step) & mask);
        end else begin
            col = (start_col & ~mask) | ((start_col + step) & mask);
        end
    end
endmodule // sdi_burst_addr

// ---- sdi_core.v ----
// Command front end of a 64-bit synchronous DRAM: mode register, bank
// tracking, burst sequencing, read latency and auto precharge.
// Assumes a controller that meets power-up and command spacing timings.
//
// Overview of operation
// - All inputs sampled on rising clock edge.
// - 64-bit data, four 16-bit chips, 32M deep.
// - Four banks, 8192 rows, 1024 columns each.
// - ACTIVE picks bank and row first.
// - Address 0-9 with READ/WRITE gives column.
// - Burst columns generated internally in order.
// - Lengths 1,2,4,8,page; terminate cuts burst.
// - Auto precharge closes row after burst.
// - New column accepted every clock cycle.
// - Auto refresh and power-down supported.
// - Mode register undefined until loaded; reset here clears it to 13'h0000.
// - Load mode command writes, value retained.
// - Mode fields: length, order, latency, mode, write.
// - Read latency two or three cycles.
// - Operating mode bits must be zero.
// - Write-burst bit forces single writes.
// - Bursts wrap within aligned block or row.
module sdi_core #(
    parameter DQ_W = 64,
    parameter ROW_W = 13,
    parameter COL_W = 10
) (
    input wire core_clk,
    input wire rst,
    input wire clk_en,
    input wire cke,
    input wire cs_n,
    input wire ras_n,
    input wire cas_n,
    input wire we_n,
    input wire bank_select_low,
    input wire bank_select_high,
    input wire [ROW_W-1:0] row_address_lines,
    input wire [DQ_W-1:0] dq_in,
    output reg [DQ_W-1:0] dq_out_r,
    output reg dq_oe_r,
    output reg [12:0] operating_mode_setup_r,
    output reg mode_loaded_r,
    output reg [3:0] bank_open_r,
    output reg [1:0] acc_bank_r,
    output reg [ROW_W-1:0] acc_row_r,
    output reg [COL_W-1:0] acc_col_r,
    output reg acc_rd_r,
    output reg acc_wr_r,
    output reg [DQ_W-1:0] wr_data_r,
    output reg refresh_r,
    output reg power_down_r,
    output reg mode_error_r
);
`include "sdi_regs.vh"
    // ----------------------------------------
    // Command decode
    // ----------------------------------------
    wire [3:0] cmd = cke ? {cs_n, ras_n, cas_n, we_n} : `SDI_CMD_NOP;
    wire [1:0] bank_in = {bank_select_high, bank_select_low};
    wire [COL_W-1:0] column_address_lines = row_address_lines[COL_W-1:0];
    wire auto_pre = row_address_lines[`SDI_AP_BIT];
    wire [2:0] bl = operating_mode_setup_r[`SDI_BL_MSB:`SDI_BL_LSB];
    wire bt = operating_mode_setup_r[`SDI_BT_BIT];
    wire [2:0] cl = operating_mode_setup_r[`SDI_CL_MSB:`SDI_CL_LSB];
    wire wb_single = operating_mode_setup_r[`SDI_WB_BIT];

    function [COL_W:0] burst_count;
        input [2:0] code;
        begin
            case (code)
                `SDI_BL_1: burst_count = {{COL_W{1'b0}}, 1'b1};
                `SDI_BL_2: burst_count = {{(COL_W-1){1'b0}}, 2'h2};
                `SDI_BL_4: burst_count = {{(COL_W-2){1'b0}}, 3'h4};
                `SDI_BL_8: burst_count = {{(COL_W-3){1'b0}}, 4'h8};
                `SDI_BL_PAGE: burst_count = `SDI_PAGE_COLS;
                default: burst_count = {{COL_W{1'b0}}, 1'b1};
            endcase
        end
    endfunction

    // ----------------------------------------
    // Burst state
    // ----------------------------------------
    localparam ST_IDLE = 2'd0;
    localparam ST_READ = 2'd1;
    localparam ST_WRITE = 2'd2;
    reg [1:0] state_r;
    reg [COL_W-1:0] start_r;
    reg [COL_W-1:0] step_r;
    reg [COL_W:0] len_r;
    reg [1:0] bbank_r;
    reg ap_r;
    reg [2:0] bl_eff_r;
    reg [ROW_W-1:0] row_mem [0:3];
    reg [2:0] pre_cnt_r [0:3];
    reg rd_pipe_r;
    reg [DQ_W-1:0] mem_r [0:255];
    reg [DQ_W-1:0] rd_d1_r;
    wire [COL_W-1:0] gen_col;
    integer i;

    sdi_burst_addr #(.COL_W(COL_W)) u_addr (
        .start_col(start_r),
        .step(step_r),
        .burst_len(bl_eff_r),
        .interleaved(bt),
        .col(gen_col)
    );

    wire bursting = (state_r != ST_IDLE);
    wire last_beat = bursting && ({1'b0, step_r} + 1'b1 == len_r);
    wire [7:0] mem_idx = {bbank_r, gen_col[5:0]};

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always @(posedge core_clk) begin
        if (rst) begin
            state_r <= ST_IDLE;
            start_r <= {COL_W{1'b0}};
            step_r <= {COL_W{1'b0}};
            len_r <= {(COL_W+1){1'b0}};
            bbank_r <= 2'h0;
            ap_r <= 1'b0;
            bl_eff_r <= `SDI_BL_1;
            operating_mode_setup_r <= `SDI_MODE_RESET;
            mode_loaded_r <= 1'b0;
            bank_open_r <= 4'h0;
            acc_bank_r <= 2'h0;
            acc_row_r <= {ROW_W{1'b0}};
            acc_col_r <= {COL_W{1'b0}};
            acc_rd_r <= 1'b0;
            acc_wr_r <= 1'b0;
            wr_data_r <= {DQ_W{1'b0}};
            refresh_r <= 1'b0;
            power_down_r <= 1'b0;
            mode_error_r <= 1'b0;
            rd_pipe_r <= 1'b0;
            rd_d1_r <= {DQ_W{1'b0}};
            dq_out_r <= {DQ_W{1'b0}};
            dq_oe_r <= 1'b0;
            for (i = 0; i < 4; i = i + 1) begin
                row_mem[i] <= {ROW_W{1'b0}};
                pre_cnt_r[i] <= 3'h0;
            end
        end else if (clk_en) begin
            acc_rd_r <= 1'b0;
            acc_wr_r <= 1'b0;
            refresh_r <= 1'b0;
            power_down_r <= !cke && (bank_open_r == 4'h0);
            // Self-timed precharge counters
            for (i = 0; i < 4; i = i + 1) begin
                if (pre_cnt_r[i] != 3'h0) begin
                    pre_cnt_r[i] <= pre_cnt_r[i] - 3'h1;
                    if (pre_cnt_r[i] == 3'h1)
                        bank_open_r[i] <= 1'b0;
                end
            end
            // Beat of current burst
            if (bursting) begin
                acc_bank_r <= bbank_r;
                acc_row_r <= row_mem[bbank_r];
                acc_col_r <= gen_col;
                acc_rd_r <= (state_r == ST_READ);
                acc_wr_r <= (state_r == ST_WRITE);
                if (state_r == ST_WRITE) begin
                    wr_data_r <= dq_in;
                    mem_r[mem_idx] <= dq_in;
                end
                step_r <= step_r + 1'b1;
                if (last_beat) begin
                    state_r <= ST_IDLE;
                    if (ap_r)
                        pre_cnt_r[bbank_r] <= `SDI_TRP_CYC;
                end
            end
            case (cmd)
                `SDI_CMD_ACT: begin
                    bank_open_r[bank_in] <= 1'b1;
                    row_mem[bank_in] <= row_address_lines;
                end
                `SDI_CMD_RD, `SDI_CMD_WR: begin
                    // New column every cycle restarts the burst
                    state_r <= (cmd == `SDI_CMD_RD) ? ST_READ : ST_WRITE;
                    start_r <= column_address_lines;
                    step_r <= {COL_W{1'b0}};
                    bbank_r <= bank_in;
                    ap_r <= auto_pre;
                    if (cmd == `SDI_CMD_WR && wb_single) begin
                        len_r <= {{COL_W{1'b0}}, 1'b1};
                        bl_eff_r <= `SDI_BL_1;
                    end else begin
                        len_r <= burst_count(bl);
                        bl_eff_r <= bl;
                    end
                end
                `SDI_CMD_BST: state_r <= ST_IDLE;
                `SDI_CMD_PRE: begin
                    for (i = 0; i < 4; i = i + 1)
                        if (auto_pre || bank_in == i[1:0])
                            bank_open_r[i] <= 1'b0;
                end
                `SDI_CMD_REF: refresh_r <= 1'b1;
                `SDI_CMD_LMR: begin
                    // Load only honoured with every bank idle
                    if (bank_open_r == 4'h0) begin
                        operating_mode_setup_r <= row_address_lines[12:0];
                        mode_loaded_r <= 1'b1;
                        mode_error_r <= (row_address_lines[`SDI_OPM_MSB:`SDI_OPM_LSB]
                            != `SDI_OPM_NORMAL) ||
                            (row_address_lines[`SDI_CL_MSB:`SDI_CL_LSB] != `SDI_CL_2 &&
                            row_address_lines[`SDI_CL_MSB:`SDI_CL_LSB] != `SDI_CL_3);
                    end
                end
                default: begin
                end
            endcase
            // Data drives from the edge before latency expires, so it is valid by then
            // Latency two reads the array directly, three adds one stage
            rd_pipe_r <= (state_r == ST_READ);
            rd_d1_r <= mem_r[mem_idx];
            if (cl == `SDI_CL_3) begin
                dq_oe_r <= rd_pipe_r;
                dq_out_r <= rd_d1_r;
            end else begin
                dq_oe_r <= (state_r == ST_READ);
                dq_out_r <= mem_r[mem_idx];
            end
        end
    end
endmodule // sdi_core

// ---- sdi_ctrl_model.sv ----
// Behavioural memory controller that drives the command and address pins.
// Assumes the bench calls issue and init, and that the clock is running.
`include "sdi_regs.vh"
module sdi_ctrl_model #(
    parameter int WAIT = 10000
) (
    input wire logic core_clk,
    output logic cke,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic bank_select_low,
    output logic bank_select_high,
    output logic [12:0] row_address_lines,
    output logic [63:0] dq_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [63:0] wdata = 64'h0;
    // Bench lowers this to reach power-down
    logic cke_lvl = 1'b1;
    initial begin
        {cke, cs_n, ras_n, cas_n, we_n} = 5'h17;
        {bank_select_high, bank_select_low} = 2'h0;
        row_address_lines = 13'h0000;
        dq_in = 64'h0;
    end
    // ----------------------------------------
    // Command issue
    // ----------------------------------------
    task issue(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a);
        @(posedge core_clk);
        {cs_n, ras_n, cas_n, we_n} <= c;
        cke <= cke_lvl;
        {bank_select_high, bank_select_low} <= b;
        // Idle address toggles, so a stale value never passes for a real one
        row_address_lines <= (c == `SDI_CMD_NOP) ? ~row_address_lines : a;
        dq_in <= wdata;
    endtask
    task init(input logic [12:0] mode);
        repeat (WAIT) issue(`SDI_CMD_NOP, 2'h0, 13'h0000);
        issue(`SDI_CMD_PRE, 2'h0, 13'h0400);
        repeat (2) begin
            repeat (3) issue(`SDI_CMD_NOP, 2'h0, 13'h0000);
            issue(`SDI_CMD_REF, 2'h0, 13'h0000);
        end
        repeat (3) issue(`SDI_CMD_NOP, 2'h0, 13'h0000);
        issue(`SDI_CMD_LMR, 2'h0, mode & 13'h0fff);
    endtask
endmodule // sdi_ctrl_model

// ---- sdi_core_chk_sva.sv ----
// Concurrent checks on the ports of the command front end.
// Assumes binding to sdi_core and the shared command codes.
`include "sdi_regs.vh"
module sdi_core_chk #(
    parameter ROW_W = 13,
    parameter COL_W = 10
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic bank_select_low,
    input wire logic bank_select_high,
    input wire logic [ROW_W-1:0] row_address_lines,
    input wire logic [12:0] operating_mode_setup_r,
    input wire logic mode_loaded_r,
    input wire logic [3:0] bank_open_r,
    input wire logic [COL_W-1:0] acc_col_r,
    input wire logic acc_rd_r,
    input wire logic acc_wr_r,
    input wire logic dq_oe_r,
    input wire logic refresh_r,
    input wire logic mode_error_r
);
    timeunit 1ns;
    timeprecision 1ns;
    wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
    wire take = clk_en && cke;
    wire idle = bank_open_r == 4'h0;
    wire cl3 = operating_mode_setup_r[6:4] == `SDI_CL_3;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    chk_mode_load: assert property (take && cmd == `SDI_CMD_LMR && idle |=>
        operating_mode_setup_r == $past(row_address_lines) && mode_loaded_r)
        else $error("mode load lost");
    chk_bank_open: assert property (take && cmd == `SDI_CMD_ACT |=>
        bank_open_r[$past({bank_select_high, bank_select_low})])
        else $error("bank not opened");
    chk_first_col: assert property (take && cmd[3:1] == 3'h2 |=> ##1
        (acc_rd_r || acc_wr_r) && acc_col_r == $past(row_address_lines[COL_W-1:0], 2))
        else $error("first column wrong");
    chk_lat_two: assert property (take && cmd == `SDI_CMD_RD && !cl3 |-> ##2 dq_oe_r)
        else $error("latency two missed");
    chk_lat_three: assert property (take && cmd == `SDI_CMD_RD && cl3 |-> ##3 dq_oe_r)
        else $error("latency three missed");
    chk_ref_pulse: assert property (take && cmd == `SDI_CMD_REF |=> refresh_r)
        else $error("refresh pulse missing");
    chk_single_wr: assert property (take && cmd == `SDI_CMD_WR &&
        operating_mode_setup_r[9] ##1 cmd == `SDI_CMD_NOP |=> ##1 !acc_wr_r)
        else $error("write not single");
    chk_mode_err: assert property (take && cmd == `SDI_CMD_LMR && idle &&
        row_address_lines[8:7] != 2'h0 |=> mode_error_r)
        else $error("mode error not flagged");
    cover property (take && cmd == `SDI_CMD_LMR);
    cover property (acc_rd_r ##3 dq_oe_r);
    cover property (take && cmd == `SDI_CMD_REF);
endmodule // sdi_core_chk
bind sdi_core sdi_core_chk #(.ROW_W(ROW_W), .COL_W(COL_W)) u_sdi_core_chk (.core_clk, .rst,
    .clk_en, .cke, .cs_n, .ras_n, .cas_n, .we_n, .bank_select_low, .bank_select_high,
    .row_address_lines, .operating_mode_setup_r, .mode_loaded_r, .bank_open_r, .acc_col_r,
    .acc_rd_r, .acc_wr_r, .dq_oe_r, .refresh_r, .mode_error_r);

// ---- sdi_core_tb.sv ----
// Self-checking bench for the command front end, fed by the controller model.
// Assumes the checker is bound separately; clock enable is held high.
`include "sdi_regs.vh"
module sdi_core_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [63:0] D = 64'hA5C3_0F1E_7788_9911;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic cke, cs_n, ras_n, cas_n, we_n, bank_select_low, bank_select_high;
    logic [12:0] row_address_lines, operating_mode_setup_r, acc_row_r;
    logic [63:0] dq_in, dq_out_r, wr_data_r;
    logic dq_oe_r, mode_loaded_r, acc_rd_r, acc_wr_r, mode_error_r, refresh_r, power_down_r;
    logic [3:0] bank_open_r;
    logic [1:0] acc_bank_r;
    logic [9:0] acc_col_r;
    int num_errors = 0;
    int compares = 0;
    always #5 core_clk = ~core_clk;
    sdi_core u_sdi_core (.core_clk, .rst, .clk_en(1'b1), .cke, .cs_n, .ras_n, .cas_n, .we_n,
        .bank_select_low, .bank_select_high, .row_address_lines, .dq_in, .dq_out_r, .dq_oe_r,
        .operating_mode_setup_r, .mode_loaded_r, .bank_open_r, .acc_bank_r, .acc_row_r,
        .acc_col_r, .acc_rd_r, .acc_wr_r, .wr_data_r, .refresh_r, .power_down_r,
        .mode_error_r);
    sdi_ctrl_model u_sdi_ctrl_model (.core_clk, .cke, .cs_n, .ras_n, .cas_n, .we_n,
        .bank_select_low, .bank_select_high, .row_address_lines, .dq_in);
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task check(input logic [63:0] s, input logic [63:0] e);
        compares++;
        if (s !== e) begin
            num_errors++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
        end
    endtask
    task print_verdict;
        if (num_errors == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task cmd(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a);
        u_sdi_ctrl_model.issue(c, b, a);
    endtask
    task step(input int n);
        repeat (n) begin
            u_sdi_ctrl_model.issue(`SDI_CMD_NOP, 2'h0, 13'h0000);
            #1;
        end
    endtask
    // Only bank 2 holds known data, so read data is checked there alone
    task access(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a,
                input int bl, input int il, input int cl);
        logic [9:0] e;
        logic [9:0] m;
        logic rdw;
        cmd(c, b, a);
        step(1);
        m = 10'(bl - 1);
        // Beat k of a read is valid by the edge latency cycles after command plus k
        for (int j = 0; j < bl + cl; j++) begin
            step(1);
            e = il ? a[9:0] ^ 10'(j) : (a[9:0] & ~m) | ((a[9:0] + 10'(j)) & m);
            rdw = (c == `SDI_CMD_RD) && (j + 2 >= cl) && (j + 2 < cl + bl);
            if (j < bl) check(64'(acc_col_r), 64'(e));
            check(64'({acc_rd_r, acc_wr_r}), 64'(j >= bl ? 0 : (c == `SDI_CMD_RD ? 2 : 1)));
            check(64'(dq_oe_r), 64'(rdw));
            if (rdw && b == 2'h2) check(dq_out_r, D);
        end
    endtask
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        u_sdi_ctrl_model.init(13'h0022);
        step(2);
        check(64'(operating_mode_setup_r), 64'h0022);
        check(64'(mode_loaded_r), 64'h1);
        cmd(`SDI_CMD_ACT, 2'h2, 13'h1ABC);
        step(2);
        check(64'(bank_open_r), 64'h4);
        u_sdi_ctrl_model.wdata = D;
        access(`SDI_CMD_WR, 2'h2, 13'h0006, 4, 0, 0);
        check(64'(acc_row_r), 64'h1ABC);
        check(64'(acc_bank_r), 64'h2);
        check(wr_data_r, D);
        access(`SDI_CMD_RD, 2'h2, 13'h0006, 4, 0, 2);
        cmd(`SDI_CMD_LMR, 2'h0, 13'h0033);
        step(2);
        check(64'(operating_mode_setup_r), 64'h0022);
        cmd(`SDI_CMD_PRE, 2'h0, 13'h0400);
        step(3);
        cmd(`SDI_CMD_LMR, 2'h0, 13'h003B);
        step(3);
        check(64'(operating_mode_setup_r), 64'h003B);
        check(64'(mode_error_r), 64'h0);
        cmd(`SDI_CMD_ACT, 2'h1, 13'h0123);
        step(2);
        access(`SDI_CMD_RD, 2'h1, 13'h0405, 8, 1, 3);
        check(64'(bank_open_r), 64'h0);
        cmd(`SDI_CMD_LMR, 2'h0, 13'h0222);
        step(3);
        cmd(`SDI_CMD_ACT, 2'h3, 13'h0042);
        step(2);
        // Bank 0 closes while bank 3 keeps bursting
        cmd(`SDI_CMD_ACT, 2'h0, 13'h0077);
        cmd(`SDI_CMD_RD, 2'h3, 13'h0000);
        cmd(`SDI_CMD_PRE, 2'h0, 13'h0000);
        step(5);
        check(64'(bank_open_r), 64'h8);
        access(`SDI_CMD_WR, 2'h3, 13'h0002, 1, 0, 1);
        cmd(`SDI_CMD_PRE, 2'h0, 13'h0400);
        step(3);
        cmd(`SDI_CMD_REF, 2'h0, 13'h0000);
        step(1);
        check(64'(refresh_r), 64'h1);
        step(2);
        cmd(`SDI_CMD_LMR, 2'h0, 13'h01A2);
        step(2);
        check(64'(mode_error_r), 64'h1);
        u_sdi_ctrl_model.cke_lvl = 1'b0;
        step(2);
        check(64'(power_down_r), 64'h1);
        print_verdict();
    end
    // Power-up wait alone is 100 us, so twice that covers the whole run
    initial begin
        #200_000;
        num_errors++;
        print_verdict();
    end
endmodule // sdi_core_tb
